/* File: rtl/spc_speed_profile_regs.sv */
`timescale 1ns/1ps

module spc_speed_profile_regs #(
   parameter int ADR_W = 12
) (
   // clock and reset
   input  wire logic             clk_i,
   input  wire logic             rst_i,
   // wishbone slave
   input  wire logic             wb_cyc_i,
   input  wire logic             wb_stb_i,
   input  wire logic             wb_we_i,
   input  wire logic [ADR_W-1:0] wb_adr_i,
   input  wire logic [3:0]       wb_sel_i,
   input  wire logic [31:0]      wb_dat_i,
   output logic      [31:0]      wb_dat_o,
   output logic                  wb_ack_o,
   // mode and duty thresholds
   output logic      [1:0]       profile_mode_o,
   output logic      [7:0]       first_turn_on_duty_o,
   output logic      [7:0]       first_turn_off_duty_o,
   output logic      [7:0]       first_clamp_duty_o,
   output logic      [7:0]       second_turn_on_duty_o,
   output logic      [7:0]       second_turn_off_duty_o,
   output logic      [7:0]       second_clamp_duty_o,
   output logic      [4:0]       reference_duty_hysteresis_o,
   // duty breakpoints
   output logic      [7:0]       duty_a_o,
   output logic      [7:0]       duty_b_o,
   output logic      [7:0]       duty_c_o,
   output logic      [7:0]       duty_d_o,
   output logic      [7:0]       duty_e_o,
   // speed thresholds and breakpoints
   output logic      [7:0]       first_turn_off_speed_o,
   output logic      [7:0]       first_clamp_speed_o,
   output logic      [7:0]       speed_a_o,
   output logic      [7:0]       speed_b_o,
   // maximum speed
   output logic      [13:0]      max_speed_o,
   output logic      [11:0]      max_elec_hz_o
);

   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   // hyst and elec_hz kept as flops so those outputs come from registers
   typedef struct packed {
      logic [31:0] word1;
      logic [31:0] word2;
      logic [31:0] word3;
      logic [31:0] word4;
      logic [31:0] word5;
      logic [31:0] max_speed;
      logic [31:0] dat;
      logic        ack;
      logic [4:0]  hyst;
      logic [11:0] elec_hz;
   } spc_state_t;

   spc_state_t s;
   spc_state_t next_s;

   logic       access;
   logic       wr;
   logic [9:0] widx;
   logic       wr_w1;
   logic       wr_w2;
   logic       wr_w3;
   logic       wr_w4;
   logic       wr_w5;
   logic       wr_ms;
   logic [7:0] joined_a;
   logic [7:0] joined_e;
   logic [7:0] joined_b;
   logic       pend_a;
   logic       pend_e;
   logic       pend_b;

   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   // byte-lane merge limited to the writable bits
   function automatic logic [31:0] spc_merge(
      input logic [31:0] old_v,
      input logic [31:0] new_v,
      input logic [3:0]  sel,
      input logic [31:0] mask
   );
      logic [31:0] lanes;
      lanes = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}} & mask;
      return (old_v & ~lanes) | (new_v & lanes);
   endfunction

   function automatic logic [4:0] spc_hyst(
      input logic [1:0] mode,
      input logic [1:0] code
   );
      logic [4:0] h;
      h = spc_pkg::HYST_0P0;
      if (mode == spc_pkg::SPC_SPEED_REF)
      begin
         case (code)
            2'h0:    h = spc_pkg::HYST_0P0;
            2'h1:    h = spc_pkg::HYST_0P5;
            2'h2:    h = spc_pkg::HYST_1P0;
            2'h3:    h = spc_pkg::HYST_2P0;
            default: h = spc_pkg::HYST_0P0;
         endcase
      end
      return h;
   endfunction

   // read mux; status shows which split codes still wait for their low half
   function automatic logic [31:0] spc_rdata(
      input logic [9:0]  idx,
      input spc_state_t  st,
      input logic [2:0]  pend
   );
      logic [31:0] r;
      case (idx)
         spc_pkg::IDX_WORD1:     r = st.word1;
         spc_pkg::IDX_WORD2:     r = st.word2;
         spc_pkg::IDX_WORD3:     r = st.word3;
         spc_pkg::IDX_WORD4:     r = st.word4;
         spc_pkg::IDX_WORD5:     r = st.word5;
         spc_pkg::IDX_MAX_SPEED: r = st.max_speed;
         spc_pkg::IDX_STATUS:    r = {29'h00000000, pend};
         default:                r = 32'h00000000;
      endcase
      return r;
   endfunction

   // ------------------------------------------------------------
   // bus decode
   // ------------------------------------------------------------
   // ack is a single-cycle pulse; a set s.ack blocks a repeat
   assign access = wb_cyc_i & wb_stb_i & ~s.ack;
   assign wr     = access & wb_we_i;
   assign widx   = wb_adr_i[11:2];

   // ------------------------------------------------------------
   // write decode
   // ------------------------------------------------------------
   // one-hot strobes shared by the word merges and the joiners;
   // a write to status or an unmapped index strobes nothing
   always_comb
   begin
      wr_w1 = 1'b0;
      wr_w2 = 1'b0;
      wr_w3 = 1'b0;
      wr_w4 = 1'b0;
      wr_w5 = 1'b0;
      wr_ms = 1'b0;
      if (wr)
      begin
         case (widx)
            spc_pkg::IDX_WORD1:     wr_w1 = 1'b1;
            spc_pkg::IDX_WORD2:     wr_w2 = 1'b1;
            spc_pkg::IDX_WORD3:     wr_w3 = 1'b1;
            spc_pkg::IDX_WORD4:     wr_w4 = 1'b1;
            spc_pkg::IDX_WORD5:     wr_w5 = 1'b1;
            spc_pkg::IDX_MAX_SPEED: wr_ms = 1'b1;
            default:                wr_ms = 1'b0;
         endcase
      end
   end

   // ------------------------------------------------------------
   // next state
   // ------------------------------------------------------------
   always_comb
   begin
      next_s     = s;
      next_s.ack = access;
      next_s.dat = 32'h00000000;

      if (wr_w1)
      begin
         next_s.word1 = spc_merge(s.word1, wb_dat_i, wb_sel_i, spc_pkg::MASK_FULL);
      end
      if (wr_w2)
      begin
         next_s.word2 = spc_merge(s.word2, wb_dat_i, wb_sel_i, spc_pkg::MASK_FULL);
      end
      if (wr_w3)
      begin
         next_s.word3 = spc_merge(s.word3, wb_dat_i, wb_sel_i, spc_pkg::MASK_FULL);
      end
      if (wr_w4)
      begin
         next_s.word4 = spc_merge(s.word4, wb_dat_i, wb_sel_i, spc_pkg::MASK_FULL);
      end
      // only bits 31:30 are kept here; bit 30 is the speed B low bit
      if (wr_w5)
      begin
         next_s.word5 = spc_merge(s.word5, wb_dat_i, wb_sel_i, spc_pkg::MASK_WORD5);
      end
      if (wr_ms)
      begin
         next_s.max_speed = spc_merge(s.max_speed, wb_dat_i, wb_sel_i, spc_pkg::MASK_MAX_SPEED);
      end

      if (access & ~wb_we_i)
      begin
         next_s.dat = spc_rdata(widx, s, {pend_b, pend_e, pend_a});
      end

      // hysteresis follows the mode as it stands after this write
      next_s.hyst = spc_hyst(next_s.word1[spc_pkg::MODE_LSB +: spc_pkg::MODE_W],
                             next_s.word3[spc_pkg::HYST_LSB +: spc_pkg::HYST_W]);
      // electrical hertz is value over six
      next_s.elec_hz = 12'(next_s.max_speed[spc_pkg::MAX_SPEED_LSB +: spc_pkg::MAX_SPEED_W]
                           / spc_pkg::ELEC_HZ_DIV);
   end

   // reset clears reserved bits as well
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         s <= '0;
      end
      else
      begin
         s <= next_s;
      end
   end

   // ------------------------------------------------------------
   // split fields
   // ------------------------------------------------------------
   // a lone high-part write leaves the old joined code in use;
   // the value changes only with the low-part write

   spc_split_join #(
      .HI_W (spc_pkg::DUTY_A_HI_W),
      .LO_W (spc_pkg::DUTY_A_LO_W)
   ) u_duty_a (
      .clk_i     (clk_i),
      .rst_i     (rst_i),
      .hi_wr_i   (wr_w1),
      .lo_wr_i   (wr_w2),
      .hi_i      (next_s.word1[spc_pkg::DUTY_A_HI_LSB +: spc_pkg::DUTY_A_HI_W]),
      .lo_i      (next_s.word2[spc_pkg::DUTY_A_LO_LSB +: spc_pkg::DUTY_A_LO_W]),
      .value_o   (joined_a),
      .pending_o (pend_a)
   );

   spc_split_join #(
      .HI_W (spc_pkg::DUTY_E_HI_W),
      .LO_W (spc_pkg::DUTY_E_LO_W)
   ) u_duty_e (
      .clk_i     (clk_i),
      .rst_i     (rst_i),
      .hi_wr_i   (wr_w2),
      .lo_wr_i   (wr_w3),
      .hi_i      (next_s.word2[spc_pkg::DUTY_E_HI_LSB +: spc_pkg::DUTY_E_HI_W]),
      .lo_i      (next_s.word3[spc_pkg::DUTY_E_LO_LSB +: spc_pkg::DUTY_E_LO_W]),
      .value_o   (joined_e),
      .pending_o (pend_e)
   );

   // speed B upper part in word four
   spc_split_join #(
      .HI_W (spc_pkg::SPD_B_HI_W),
      .LO_W (spc_pkg::SPD_B_LO_W)
   ) u_speed_b (
      .clk_i     (clk_i),
      .rst_i     (rst_i),
      .hi_wr_i   (wr_w4),
      .lo_wr_i   (wr_w5),
      .hi_i      (next_s.word4[spc_pkg::SPD_B_HI_LSB +: spc_pkg::SPD_B_HI_W]),
      .lo_i      (next_s.word5[spc_pkg::SPD_B_LO_LSB +: spc_pkg::SPD_B_LO_W]),
      .value_o   (joined_b),
      .pending_o (pend_b)
   );

   // ------------------------------------------------------------
   // outputs
   // ------------------------------------------------------------
   assign wb_dat_o = s.dat;
   assign wb_ack_o = s.ack;

   assign profile_mode_o = s.word1[spc_pkg::MODE_LSB +: spc_pkg::MODE_W];
   assign first_turn_on_duty_o = s.word1[spc_pkg::ON1_LSB +: spc_pkg::DUTY_W];
   assign first_turn_off_duty_o = s.word1[spc_pkg::OFF1_LSB +: spc_pkg::DUTY_W];
   assign first_clamp_duty_o = s.word1[spc_pkg::CLAMP1_LSB +: spc_pkg::DUTY_W];

   assign second_turn_on_duty_o  = s.word3[spc_pkg::ON2_LSB +: spc_pkg::DUTY_W];
   assign second_turn_off_duty_o = s.word3[spc_pkg::OFF2_LSB +: spc_pkg::DUTY_W];
   assign second_clamp_duty_o    = s.word3[spc_pkg::CLAMP2_LSB +: spc_pkg::DUTY_W];
   assign reference_duty_hysteresis_o = s.hyst;

   assign duty_b_o = s.word2[spc_pkg::DUTY_B_LSB +: spc_pkg::DUTY_W];
   assign duty_c_o = s.word2[spc_pkg::DUTY_C_LSB +: spc_pkg::DUTY_W];
   assign duty_d_o = s.word2[spc_pkg::DUTY_D_LSB +: spc_pkg::DUTY_W];
   assign duty_a_o = joined_a;
   assign duty_e_o = joined_e;
   assign speed_b_o = joined_b;

   assign first_turn_off_speed_o = s.word4[spc_pkg::SPD_OFF1_LSB +: spc_pkg::DUTY_W];
   assign first_clamp_speed_o = s.word4[spc_pkg::SPD_CLAMP1_LSB +: spc_pkg::DUTY_W];
   assign speed_a_o = s.word4[spc_pkg::SPD_A_LSB +: spc_pkg::DUTY_W];

   assign max_speed_o   = s.max_speed[spc_pkg::MAX_SPEED_LSB +: spc_pkg::MAX_SPEED_W];
   assign max_elec_hz_o = s.elec_hz;

endmodule

/* File: rtl/spc_pkg.sv */
package spc_pkg;

   // ------------------------------------------------------------
   // register indices (byte address is four times the index)
   // ------------------------------------------------------------
   localparam logic [9:0] IDX_MAX_SPEED = 10'h08E;
   localparam logic [9:0] IDX_WORD1     = 10'h094;
   localparam logic [9:0] IDX_WORD2     = 10'h096;
   localparam logic [9:0] IDX_WORD3     = 10'h098;
   localparam logic [9:0] IDX_WORD4     = 10'h09A;
   localparam logic [9:0] IDX_WORD5     = 10'h09C;
   localparam logic [9:0] IDX_STATUS    = 10'h0A0;

   // ------------------------------------------------------------
   // writable bits and reset values
   // ------------------------------------------------------------
   localparam logic [31:0] MASK_FULL      = 32'hFFFFFFFF;
   localparam logic [31:0] MASK_WORD5     = 32'hC0000000;
   localparam logic [31:0] MASK_MAX_SPEED = 32'h80003FFF;
   localparam logic [31:0] RST_WORD       = 32'h00000000;

   // ------------------------------------------------------------
   // field layout
   // ------------------------------------------------------------
   localparam int DUTY_W       = 8;
   localparam int MODE_W       = 2;
   localparam int HYST_W       = 2;
   localparam int MAX_SPEED_W  = 14;
   localparam int ELEC_HZ_W    = 12;
   localparam int MODE_LSB     = 29;
   localparam int ON1_LSB      = 21;
   localparam int OFF1_LSB     = 13;
   localparam int CLAMP1_LSB   = 5;
   localparam int DUTY_A_HI_W  = 5;
   localparam int DUTY_A_HI_LSB = 0;
   localparam int DUTY_A_LO_W  = 3;
   localparam int DUTY_A_LO_LSB = 28;
   localparam int DUTY_B_LSB   = 20;
   localparam int DUTY_C_LSB   = 12;
   localparam int DUTY_D_LSB   = 4;
   localparam int DUTY_E_HI_W  = 4;
   localparam int DUTY_E_HI_LSB = 0;
   localparam int DUTY_E_LO_W  = 4;
   localparam int DUTY_E_LO_LSB = 27;
   localparam int ON2_LSB      = 19;
   localparam int OFF2_LSB     = 11;
   localparam int CLAMP2_LSB   = 3;
   localparam int HYST_LSB     = 1;
   localparam int SPD_OFF1_LSB = 23;
   localparam int SPD_CLAMP1_LSB = 15;
   localparam int SPD_A_LSB    = 7;
   localparam int SPD_B_HI_W   = 7;
   localparam int SPD_B_HI_LSB = 0;
   localparam int SPD_B_LO_W   = 1;
   localparam int SPD_B_LO_LSB = 30;
   localparam int MAX_SPEED_LSB = 0;

   // ------------------------------------------------------------
   // scaling
   // ------------------------------------------------------------
   // codes mean code/255 of full scale
   localparam int DUTY_FULL_CODE = 255;
   localparam logic [13:0] ELEC_HZ_DIV = 14'h0006;

   // hysteresis in tenths of a percent
   localparam logic [4:0] HYST_0P0 = 5'h00;
   localparam logic [4:0] HYST_0P5 = 5'h05;
   localparam logic [4:0] HYST_1P0 = 5'h0A;
   localparam logic [4:0] HYST_2P0 = 5'h14;

   typedef enum logic [1:0] {
      SPC_SPEED_REF,
      SPC_LINEAR,
      SPC_STAIRCASE,
      SPC_FWD_REV
   } spc_mode_t;

endpackage

/* File: rtl/spc_split_join.sv */
`timescale 1ns/1ps

module spc_split_join #(
   parameter int HI_W = 5,
   parameter int LO_W = 3
) (
   // clock and reset
   input  wire logic                 clk_i,
   input  wire logic                 rst_i,
   // word write strobes
   input  wire logic                 hi_wr_i,
   input  wire logic                 lo_wr_i,
   // parts as they will stand after the write
   input  wire logic [HI_W-1:0]      hi_i,
   input  wire logic [LO_W-1:0]      lo_i,
   // joined value and partial-update flag
   output logic      [HI_W+LO_W-1:0] value_o,
   output logic                      pending_o
);

   typedef struct packed {
      logic [HI_W+LO_W-1:0] value;
      logic                 pending;
   } spc_sj_state_t;

   spc_sj_state_t s;
   spc_sj_state_t next_s;

   always_comb
   begin
      next_s = s;
      if (hi_wr_i)
      begin
         next_s.pending = 1'b1;
      end
      if (lo_wr_i)
      begin
         next_s.value   = {hi_i, lo_i};
         next_s.pending = 1'b0;
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         s <= '0;
      end
      else
      begin
         s <= next_s;
      end
   end

   assign value_o   = s.value;
   assign pending_o = s.pending;

endmodule

/* File: testbench/spc_speed_profile_regs_chk.sv */
`timescale 1ns/1ps

module spc_speed_profile_regs_chk #(
   parameter int ADR_W = 12
) (
   // clock and reset
   input wire logic             clk_i,
   input wire logic             rst_i,
   // bus
   input wire logic             wb_cyc_i,
   input wire logic             wb_stb_i,
   input wire logic             wb_we_i,
   input wire logic [ADR_W-1:0] wb_adr_i,
   input wire logic [31:0]      wb_dat_o,
   input wire logic             wb_ack_o,
   // settings
   input wire logic [1:0]       profile_mode_o,
   input wire logic [4:0]       reference_duty_hysteresis_o,
   input wire logic [7:0]       duty_a_o,
   input wire logic [7:0]       duty_e_o,
   input wire logic [7:0]       speed_b_o,
   input wire logic [13:0]      max_speed_o,
   input wire logic [11:0]      max_elec_hz_o
);
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);

   sequence s_req;
      wb_cyc_i && wb_stb_i && !wb_ack_o;
   endsequence
   sequence s_wr(logic [9:0] idx);
      wb_ack_o && wb_we_i && wb_adr_i[11:2] == idx;
   endsequence

   property p_answer;
      s_req |=> wb_ack_o ##1 !wb_ack_o;
   endproperty
   a_answer: assert property (p_answer) else $error("ack not a single pulse after request");
   property p_dat_idle;
      !wb_ack_o |-> wb_dat_o == 32'h00000000;
   endproperty
   a_dat_idle: assert property (p_dat_idle) else $error("read data outside ack");
   property p_mode_src;
      !$past(rst_i) && $changed(profile_mode_o) |-> s_wr(spc_pkg::IDX_WORD1);
   endproperty
   a_mode_src: assert property (p_mode_src) else $error("mode moved without word1 write");
   property p_duty_a;
      !$past(rst_i) && $changed(duty_a_o) |-> s_wr(spc_pkg::IDX_WORD2);
   endproperty
   a_duty_a: assert property (p_duty_a) else $error("duty a moved off low write");
   property p_duty_e;
      !$past(rst_i) && $changed(duty_e_o) |-> s_wr(spc_pkg::IDX_WORD3);
   endproperty
   a_duty_e: assert property (p_duty_e) else $error("duty e moved off low write");
   property p_speed_b;
      !$past(rst_i) && $changed(speed_b_o) |-> s_wr(spc_pkg::IDX_WORD5);
   endproperty
   a_speed_b: assert property (p_speed_b) else $error("speed b moved off low write");
   property p_hyst_off;
      profile_mode_o != 2'h0 |-> reference_duty_hysteresis_o == 5'h00;
   endproperty
   a_hyst_off: assert property (p_hyst_off) else $error("hysteresis outside reference mode");
   property p_hyst_src;
      !$past(rst_i) && $changed(reference_duty_hysteresis_o) |-> s_wr(spc_pkg::IDX_WORD1) or s_wr(spc_pkg::IDX_WORD3);
   endproperty
   a_hyst_src: assert property (p_hyst_src) else $error("hysteresis moved without write");
   property p_elec;
      max_elec_hz_o == 12'(max_speed_o / spc_pkg::ELEC_HZ_DIV);
   endproperty
   a_elec: assert property (p_elec) else $error("electrical hertz not max over six");
   property p_max_src;
      !$past(rst_i) && $changed(max_speed_o) |-> s_wr(spc_pkg::IDX_MAX_SPEED);
   endproperty
   a_max_src: assert property (p_max_src) else $error("max speed moved without write");
endmodule

/* File: testbench/spc_speed_profile_regs_tb.sv */
`timescale 1ns/1ps

module spc_speed_profile_regs_tb;
   // ------------------------------------------------------------
   // signals
   // ------------------------------------------------------------
   logic        clk_i = 1'b0;
   logic        rst_i = 1'b1;
   logic        cyc = 1'b0;
   logic        stb = 1'b0;
   logic        we = 1'b0;
   logic [11:0] adr = 12'h000;
   logic [3:0]  sel = 4'h0;
   logic [31:0] wdat = 32'h00000000;
   logic [31:0] rdat;
   logic        ack;
   logic [1:0]  mode;
   logic [4:0]  hyst;
   logic [7:0]  on1, off1, cl1, on2, off2, cl2, da, db, dc, dd, de, so1, sc1, sa, sb;
   logic [13:0] maxs;
   logic [11:0] ehz;
   int          fails = 0;
   int          compares = 0;
   localparam logic [31:0] P1 = 32'hEB5C3A9F;
   localparam logic [31:0] P2 = 32'hD6E71C4B;
   localparam logic [31:0] P3 = 32'hB3A5F2D7;
   localparam logic [31:0] P4 = 32'hF1C8A639;
   localparam logic [9:0]  ST = spc_pkg::IDX_STATUS;
   localparam logic [4:0]  HT [4] = '{spc_pkg::HYST_0P0, spc_pkg::HYST_0P5, spc_pkg::HYST_1P0, spc_pkg::HYST_2P0};
   localparam logic [9:0]  IX [6] = '{spc_pkg::IDX_MAX_SPEED, spc_pkg::IDX_WORD1, spc_pkg::IDX_WORD2,
                                      spc_pkg::IDX_WORD3, spc_pkg::IDX_WORD4, spc_pkg::IDX_WORD5};

   always #20 clk_i = ~clk_i;

   spc_speed_profile_regs dut (
      .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
      .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .profile_mode_o(mode),
      .first_turn_on_duty_o(on1), .first_turn_off_duty_o(off1), .first_clamp_duty_o(cl1),
      .second_turn_on_duty_o(on2), .second_turn_off_duty_o(off2), .second_clamp_duty_o(cl2),
      .reference_duty_hysteresis_o(hyst), .duty_a_o(da), .duty_b_o(db), .duty_c_o(dc), .duty_d_o(dd),
      .duty_e_o(de), .first_turn_off_speed_o(so1), .first_clamp_speed_o(sc1), .speed_a_o(sa),
      .speed_b_o(sb), .max_speed_o(maxs), .max_elec_hz_o(ehz)
   );

   // ------------------------------------------------------------
   // bus and compare tasks
   // ------------------------------------------------------------
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp)
      begin
         fails++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   // ack sampled at the rising edge; the request stands until then
   task automatic bus(input logic [9:0] i, input logic w, input logic [3:0] s, input logic [31:0] d,
                      output logic [31:0] q);
      @(posedge clk_i);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= {i, 2'b00};
      sel <= s;
      wdat <= d;
      @(posedge clk_i);
      while (ack !== 1'b1)
      begin
         @(posedge clk_i);
      end
      q = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask

   task automatic wr(input logic [9:0] i, input logic [31:0] d);
      logic [31:0] q;
      bus(i, 1'b1, 4'hF, d, q);
   endtask

   task automatic rd(input logic [9:0] i, output logic [31:0] q);
      bus(i, 1'b0, 4'hF, 32'h00000000, q);
   endtask

   // ------------------------------------------------------------
   // scenarios
   // ------------------------------------------------------------
   task automatic t_reset;
      logic [31:0] q;
      foreach (IX[k])
      begin
         rd(IX[k], q);
         check(q, 32'h00000000);
      end
      check(32'(mode), 32'h0);
      check(32'(de), 32'h0);
      $display("test reset done");
   endtask

   task automatic t_fields;
      logic [31:0] q;
      wr(spc_pkg::IDX_WORD1, P1);
      wr(spc_pkg::IDX_WORD2, P2);
      wr(spc_pkg::IDX_WORD3, P3);
      wr(spc_pkg::IDX_WORD4, P4);
      wr(spc_pkg::IDX_WORD5, 32'h7FFFFFFF);
      check(32'(mode), 32'(P1[30:29]));
      check({on1, off1, cl1, da}, {P1[28:5], P1[4:0], P2[30:28]});
      check({db, dc, dd, de}, {P2[27:4], P2[3:0], P3[30:27]});
      check({on2, off2, cl2, 3'h0, hyst}, {P3[26:3], 8'h00});
      check({so1, sc1, sa, sb}, {P4[30:7], P4[6:0], 1'b1});
      rd(spc_pkg::IDX_WORD1, q);
      check(q, P1);
      rd(spc_pkg::IDX_WORD4, q);
      check(q, P4);
      rd(spc_pkg::IDX_WORD5, q);
      check(q, 32'h40000000);
      $display("test fields done");
   endtask

   task automatic t_modes;
      for (int m = 0; m < 4; m++)
      begin
         wr(spc_pkg::IDX_WORD1, {1'b0, 2'(m), 29'h0});
         check(32'(mode), 32'(m));
         for (int h = 0; h < 4; h++)
         begin
            wr(spc_pkg::IDX_WORD3, {29'h0, 2'(h), 1'b0});
            check(32'(hyst), (m == 0) ? 32'(HT[h]) : 32'h0);
         end
      end
      $display("test modes done");
   endtask

   task automatic t_split;
      logic [31:0] q;
      wr(spc_pkg::IDX_WORD1, 32'h0000001F);
      check(32'(da), {24'h0, P1[4:0], P2[30:28]});
      rd(ST, q);
      check(q, 32'h00000001);
      wr(spc_pkg::IDX_WORD2, 32'h20000000);
      check(32'(da), 32'hFA);
      rd(ST, q);
      check(q, 32'h00000002);
      wr(spc_pkg::IDX_WORD4, 32'h0000007F);
      check(32'(sb), {24'h0, P4[6:0], 1'b1});
      wr(spc_pkg::IDX_WORD5, 32'h00000000);
      check(32'(sb), 32'hFE);
      wr(spc_pkg::IDX_WORD5, 32'h40000000);
      check(32'(sb), 32'hFF);
      $display("test split done");
   endtask

   task automatic t_misc;
      logic [31:0] q;
      bus(spc_pkg::IDX_WORD3, 1'b1, 4'h5, 32'hFFFFFFFF, q);
      rd(spc_pkg::IDX_WORD3, q);
      check(q, 32'h00FF00FF);
      wr(spc_pkg::IDX_MAX_SPEED, 32'hFFFFFFFF);
      rd(spc_pkg::IDX_MAX_SPEED, q);
      check(q, 32'h80003FFF);
      check({maxs, 6'h0, ehz}, {14'h3FFF, 6'h0, 12'hAAA});
      wr(spc_pkg::IDX_MAX_SPEED, 32'h00002710);
      check(32'(ehz), 32'h682);
      wr(10'h095, 32'hFFFFFFFF);
      rd(10'h095, q);
      check(q, 32'h00000000);
      wr(ST, 32'hFFFFFFFF);
      rd(ST, q);
      check(q, 32'h00000000);
      $display("test misc done");
   endtask

   task automatic t_rerun;
      logic [31:0] q;
      wr(spc_pkg::IDX_WORD1, P1);
      wr(spc_pkg::IDX_WORD2, P2);
      @(posedge clk_i);
      rst_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      check(32'(mode), 32'h0);
      check({on1, off1, cl1, da}, 32'h00000000);
      rd(spc_pkg::IDX_WORD1, q);
      check(q, 32'h00000000);
      $display("test rerun done");
   endtask

   task automatic complete_run;
      $display("comparisons %0d mismatches %0d", compares, fails);
      if (fails == 0 && compares > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   initial
   begin
      repeat (5) @(posedge clk_i);
      rst_i <= 1'b0;
      t_reset;
      t_fields;
      t_modes;
      t_split;
      t_misc;
      t_rerun;
      complete_run;
   end

   // well above the under two hundred cycles the accesses need
   initial
   begin
      repeat (5000) @(posedge clk_i);
      fails++;
      complete_run;
   end
endmodule

bind spc_speed_profile_regs spc_speed_profile_regs_chk #(.ADR_W(ADR_W)) chk (
   .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
   .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .profile_mode_o(profile_mode_o),
   .reference_duty_hysteresis_o(reference_duty_hysteresis_o), .duty_a_o(duty_a_o), .duty_e_o(duty_e_o),
   .speed_b_o(speed_b_o), .max_speed_o(max_speed_o), .max_elec_hz_o(max_elec_hz_o)
);
